// ---- core/mie_acc_unit.v ----
`timescale 1ns/10ps
`include "mie_consts.vh"
module mie_acc_unit (
	input wire [7:0] op,
	input wire [7:0] acc,
	input wire cy,
	input wire [7:0] operand,
	output reg [7:0] res,
	output reg cy_out
);

always @*
begin
	res = acc;
	cy_out = cy;
	casez (op)
	`MIE_RL:
		res = {acc[6:0], acc[`MIE_ACC_MSB]};
	`MIE_RLC:
	begin
		res = {acc[6:0], cy};
		cy_out = acc[`MIE_ACC_MSB];
	end
	`MIE_RR:
		res = {acc[0], acc[7:1]};
	`MIE_RRC:
	begin
		res = {cy, acc[7:1]};
		cy_out = acc[0];
	end
	`MIE_SWAP:
		res = {acc[`MIE_NIB_LO], acc[`MIE_NIB_HI]};
	`MIE_XRL_IMM, `MIE_XRL_R, `MIE_XRL_I:
		res = acc ^ operand;
	`MIE_LOW_NIBBLE_EXCHANGE:
		res = {acc[`MIE_NIB_HI], operand[`MIE_NIB_LO]};
	default:
		res = acc;
	endcase
end

endmodule // mie_acc_unit

// ---- core/mie_consts.vh ----
`ifndef MIE_CONSTS_VH
`define MIE_CONSTS_VH
`define MIE_PC_RST 12'h000
`define MIE_PC_STEP 12'h001
`define MIE_BYTE_RST 8'h00
`define MIE_SP_RST 3'h0
`define MIE_PAGE3 3'h3
`define MIE_BANK0 2'h0
`define MIE_BANK1 2'h3
`define MIE_PSW_CY 7
`define MIE_PSW_AC 6
`define MIE_PSW_F0 5
`define MIE_PSW_BS 4
`define MIE_SP_HI 2
`define MIE_ACC_MSB 7
`define MIE_NIB_HI 7:4
`define MIE_NIB_LO 3:0
`define MIE_JMP_HI 7:5
`define MIE_RL 8'hE7
`define MIE_RLC 8'hF7
`define MIE_RR 8'h77
`define MIE_RRC 8'h67
`define MIE_SWAP 8'h47
`define MIE_XRL_IMM 8'hD3
`define MIE_XRL_R 8'b11011???
`define MIE_XRL_I 8'b1101000?
`define MIE_JB 8'b???10010
`define MIE_JC 8'hF6
`define MIE_JNC 8'hE6
`define MIE_JF0 8'hB6
`define MIE_JF1 8'h76
`define MIE_JT0 8'h36
`define MIE_JNT0 8'h26
`define MIE_JT1 8'h56
`define MIE_JNT1 8'h46
`define MIE_JNI 8'h86
`define MIE_JZ 8'hC6
`define MIE_JNZ 8'h96
`define MIE_JMP 8'b???00100
`define MIE_PAGE_INDIRECT_JUMP 8'hB3
`define MIE_ENI 8'h05
`define MIE_DISI 8'h15
`define MIE_SELECT_PROGRAM_BANK_LOW 8'hE5
`define MIE_SEL_MB1 8'hF5
`define MIE_SEL_RB0 8'hC5
`define MIE_SELECT_REGISTER_BANK_HIGH 8'hD5
`define MIE_MOV_A_IMM 8'h23
`define MIE_MOV_A_R 8'b11111???
`define MIE_MOV_A_I 8'b1111000?
`define MIE_MOV_A_PSW 8'hC7
`define MIE_MOV_R_IMM 8'b10111???
`define MIE_MOV_R_A 8'b10101???
`define MIE_MOV_I_A 8'b1010000?
`define MIE_MOV_I_IMM 8'b1011000?
`define MIE_MOV_PSW_A 8'hD7
`define MIE_CURRENT_PAGE_TABLE_READ 8'hA3
`define MIE_PAGE_THREE_TABLE_READ 8'hE3
`define MIE_EXTERNAL_DATA_MOVE_RD 8'b1000000?
`define MIE_EXTERNAL_DATA_MOVE_WR 8'b1001000?
`define MIE_XCH_R 8'b00101???
`define MIE_XCH_I 8'b0010000?
`define MIE_LOW_NIBBLE_EXCHANGE 8'b0011000?
`define MIE_CPL_C 8'hA7
`define MIE_CPL_F0 8'h95
`define MIE_CPL_F1 8'hB5
`define MIE_CLR_C 8'h97
`define MIE_CLR_F0 8'h85
`define MIE_CLR_F1 8'hA5
`endif

// ---- core/mie_exec_core.v ----
`timescale 1ns/10ps
`include "mie_consts.vh"
// Overview of operation
// - rotate left plain: top bit wraps to bit zero, carry kept
// - rotate left through carry: carry into bit zero, bit seven out
// - rotate right: plain wraps bit zero, carry form goes via carry
// - nibble swap exchanges accumulator halves, one byte, one cycle
// - immediate xor with second byte, two bytes, two cycles
// - register or indirect xor, one byte, one cycle
// - conditional jump loads low pc from byte two, else skips both
// - bit test jump picks accumulator bit from opcode top bits
// - jump on accumulator zero or nonzero within page
// - direct jump: opcode top bits, byte two, bank flag on top
// - page indirect jump via program byte at accumulator
// - one-cycle enable and disable of external interrupt
// - program bank flag set or cleared for later jumps
// - register bank switch maps registers to 0..7 or 24..31
// - move status word to accumulator and back, one cycle
// - current page table read into accumulator, two cycles
// - page three table read into accumulator, two cycles
// - external moves address by r0 or r1, two cycles
// - exchange with register or indirect; digit form low nibble
// - immediate load of register or indirect location, two cycles
// - complement or clear carry, user flag zero and one
// - register fields in opcodes are plain binary numbers
// - twelve-bit program addresses, bank flag gives top bit on direct jumps
module mie_exec_core (
	input wire clock,
	input wire arst_n,
	input wire [7:0] prog_data,
	input wire [7:0] xd_rdata,
	input wire test_input_zero,
	input wire test_input_one,
	input wire ext_int_n,
	output reg [11:0] prog_addr_ff,
	output reg prog_rd_ff,
	output reg [7:0] xd_addr_ff,
	output reg [7:0] xd_wdata_ff,
	output reg xd_rd_ff,
	output reg xd_wr_ff,
	output reg [11:0] pc_ff,
	output reg [7:0] acc_ff,
	output reg carry_ff,
	output reg aux_carry_ff,
	output reg user_flag_zero_ff,
	output reg user_flag_one_ff,
	output reg register_bank_switch_ff,
	output reg program_bank_flag_ff,
	output reg ext_int_enable_ff,
	output reg instr_done_ff
);

localparam ST_ADDR = 3'b001;
localparam ST_OPC = 3'b010;
localparam ST_ARG = 3'b100;

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [7:0] op_ff;
reg [2:0] stack_ptr_ff;
reg [11:0] nxt_pc;
reg [7:0] ram [0:127];
reg ram_we;
reg [6:0] ram_wa;
reg [7:0] ram_wd;

// working registers sit in data memory; bank picks the base
function [6:0] reg_idx;
	input bs;
	input [2:0] r;
	begin
		reg_idx = {2'b00, bs ? `MIE_BANK1 : `MIE_BANK0, r};
	end
endfunction

function two_byte;
	input [7:0] op;
	begin
		casez (op)
		`MIE_XRL_IMM, `MIE_JB, `MIE_JC, `MIE_JNC, `MIE_JF0, `MIE_JF1,
		`MIE_JT0, `MIE_JNT0, `MIE_JT1, `MIE_JNT1, `MIE_JNI, `MIE_JZ,
		`MIE_JNZ, `MIE_JMP, `MIE_MOV_A_IMM, `MIE_MOV_R_IMM,
		`MIE_MOV_I_IMM:
			two_byte = 1'b1;
		default:
			two_byte = 1'b0;
		endcase
	end
endfunction

function table_op;
	input [7:0] op;
	begin
		casez (op)
		`MIE_PAGE_INDIRECT_JUMP, `MIE_CURRENT_PAGE_TABLE_READ, `MIE_PAGE_THREE_TABLE_READ:
			table_op = 1'b1;
		default:
			table_op = 1'b0;
		endcase
	end
endfunction

function external_data_move_op;
	input [7:0] op;
	begin
		casez (op)
		`MIE_EXTERNAL_DATA_MOVE_RD, `MIE_EXTERNAL_DATA_MOVE_WR:
			external_data_move_op = 1'b1;
		default:
			external_data_move_op = 1'b0;
		endcase
	end
endfunction

// non-jumps return zero, so they fall through to the plain advance
function jump_taken;
	input [7:0] op;
	input [7:0] acc;
	input cy;
	input f0;
	input f1;
	input t0;
	input t1;
	input int_n;
	begin
		casez (op)
		`MIE_JB:
			jump_taken = acc[op[`MIE_JMP_HI]];
		`MIE_JC:
			jump_taken = cy;
		`MIE_JNC:
			jump_taken = !cy;
		`MIE_JF0:
			jump_taken = f0;
		`MIE_JF1:
			jump_taken = f1;
		`MIE_JT0:
			jump_taken = t0;
		`MIE_JNT0:
			jump_taken = !t0;
		`MIE_JT1:
			jump_taken = t1;
		`MIE_JNT1:
			jump_taken = !t1;
		`MIE_JNI:
			jump_taken = !int_n;
		`MIE_JZ:
			jump_taken = (acc == `MIE_BYTE_RST);
		`MIE_JNZ:
			jump_taken = (acc != `MIE_BYTE_RST);
		default:
			jump_taken = 1'b0;
		endcase
	end
endfunction

wire in_opc = (state_ff == ST_OPC);
wire in_arg = (state_ff == ST_ARG);
wire [7:0] cur_op = in_opc ? prog_data : op_ff;
wire long_op = two_byte(prog_data) | table_op(prog_data) |
	external_data_move_op(prog_data);
wire [6:0] r_idx = reg_idx(register_bank_switch_ff, cur_op[2:0]);
wire [6:0] p_idx = reg_idx(register_bank_switch_ff, {2'b00, cur_op[0]});
wire [7:0] r_val = ram[r_idx];
wire [7:0] ptr_val = ram[p_idx];
wire [6:0] i_idx = ptr_val[6:0];
wire [7:0] i_val = ram[i_idx];
wire [7:0] opnd = in_arg ? prog_data : (cur_op[3] ? r_val : i_val);
wire [7:0] psw_val = {carry_ff, aux_carry_ff, user_flag_zero_ff,
	register_bank_switch_ff, 1'b1, stack_ptr_ff};
wire [7:0] alu_res;
wire alu_cy;
wire taken = jump_taken(op_ff, acc_ff, carry_ff, user_flag_zero_ff,
	user_flag_one_ff, test_input_zero, test_input_one, ext_int_n);
wire [11:0] tab_addr = (prog_data == `MIE_PAGE_THREE_TABLE_READ) ?
	{nxt_pc[11], `MIE_PAGE3, acc_ff} :
	{nxt_pc[11:8], acc_ff};

mie_acc_unit u_acc (
	.op(cur_op),
	.acc(acc_ff),
	.cy(carry_ff),
	.operand(opnd),
	.res(alu_res),
	.cy_out(alu_cy)
);

always @*
begin
	case (state_ff)
	ST_ADDR:
		nxt_state = ST_OPC;
	ST_OPC:
		nxt_state = long_op ? ST_ARG : ST_OPC;
	ST_ARG:
		nxt_state = ST_OPC;
	default:
		nxt_state = ST_ADDR;
	endcase
end

always @*
begin
	nxt_pc = pc_ff;
	case (state_ff)
	ST_OPC:
		nxt_pc = pc_ff + `MIE_PC_STEP;
	ST_ARG:
	begin
		casez (op_ff)
		`MIE_JMP:
			nxt_pc = {program_bank_flag_ff, op_ff[`MIE_JMP_HI],
				prog_data};
		`MIE_PAGE_INDIRECT_JUMP:
			nxt_pc = {pc_ff[11:8], prog_data};
		`MIE_CURRENT_PAGE_TABLE_READ, `MIE_PAGE_THREE_TABLE_READ, `MIE_EXTERNAL_DATA_MOVE_RD, `MIE_EXTERNAL_DATA_MOVE_WR:
			nxt_pc = pc_ff;
		default:
			if (taken)
				nxt_pc = {pc_ff[11:8], prog_data};
			else
				nxt_pc = pc_ff + `MIE_PC_STEP;
		endcase
	end
	default:
		nxt_pc = pc_ff;
	endcase
end

// data memory writes, split out so the array needs no reset
always @*
begin
	ram_we = 1'b0;
	ram_wa = r_idx;
	ram_wd = acc_ff;
	if (in_opc)
	begin
		casez (prog_data)
		`MIE_MOV_R_A, `MIE_XCH_R:
			ram_we = 1'b1;
		`MIE_MOV_I_A, `MIE_XCH_I:
		begin
			ram_we = 1'b1;
			ram_wa = i_idx;
		end
		`MIE_LOW_NIBBLE_EXCHANGE:
		begin
			ram_we = 1'b1;
			ram_wa = i_idx;
			ram_wd = {i_val[`MIE_NIB_HI], acc_ff[`MIE_NIB_LO]};
		end
		default:
			ram_we = 1'b0;
		endcase
	end
	else if (in_arg)
	begin
		casez (op_ff)
		`MIE_MOV_R_IMM:
		begin
			ram_we = 1'b1;
			ram_wd = prog_data;
		end
		`MIE_MOV_I_IMM:
		begin
			ram_we = 1'b1;
			ram_wa = i_idx;
			ram_wd = prog_data;
		end
		default:
			ram_we = 1'b0;
		endcase
	end
end

always @(posedge clock)
begin
	if (ram_we)
		ram[ram_wa] <= ram_wd;
end

always @(posedge clock or negedge arst_n)
begin
	if (!arst_n)
	begin
		state_ff <= ST_ADDR;
		op_ff <= `MIE_BYTE_RST;
		pc_ff <= `MIE_PC_RST;
		prog_addr_ff <= `MIE_PC_RST;
		prog_rd_ff <= 1'b0;
		xd_addr_ff <= `MIE_BYTE_RST;
		xd_wdata_ff <= `MIE_BYTE_RST;
		xd_rd_ff <= 1'b0;
		xd_wr_ff <= 1'b0;
		acc_ff <= `MIE_BYTE_RST;
		carry_ff <= 1'b0;
		aux_carry_ff <= 1'b0;
		user_flag_zero_ff <= 1'b0;
		user_flag_one_ff <= 1'b0;
		register_bank_switch_ff <= 1'b0;
		program_bank_flag_ff <= 1'b0;
		ext_int_enable_ff <= 1'b0;
		stack_ptr_ff <= `MIE_SP_RST;
		instr_done_ff <= 1'b0;
	end
	else
	begin
		state_ff <= nxt_state;
		pc_ff <= nxt_pc;
		// a table read borrows the fetch address for one cycle
		prog_addr_ff <= (in_opc && table_op(prog_data)) ? tab_addr : nxt_pc;
		prog_rd_ff <= !(in_opc && external_data_move_op(prog_data));
		xd_rd_ff <= 1'b0;
		xd_wr_ff <= 1'b0;
		instr_done_ff <= (in_opc && !long_op) || in_arg;
		if (in_opc)
		begin
			op_ff <= prog_data;
			casez (prog_data)
			`MIE_RL, `MIE_RR, `MIE_SWAP, `MIE_XRL_R, `MIE_XRL_I:
				acc_ff <= alu_res;
			`MIE_RLC, `MIE_RRC:
			begin
				acc_ff <= alu_res;
				carry_ff <= alu_cy;
			end
			`MIE_ENI:
				ext_int_enable_ff <= 1'b1;
			`MIE_DISI:
				ext_int_enable_ff <= 1'b0;
			`MIE_SELECT_PROGRAM_BANK_LOW:
				program_bank_flag_ff <= 1'b0;
			`MIE_SEL_MB1:
				program_bank_flag_ff <= 1'b1;
			`MIE_SEL_RB0:
				register_bank_switch_ff <= 1'b0;
			`MIE_SELECT_REGISTER_BANK_HIGH:
				register_bank_switch_ff <= 1'b1;
			`MIE_MOV_A_PSW:
				acc_ff <= psw_val;
			`MIE_MOV_PSW_A:
			begin
				carry_ff <= acc_ff[`MIE_PSW_CY];
				aux_carry_ff <= acc_ff[`MIE_PSW_AC];
				user_flag_zero_ff <= acc_ff[`MIE_PSW_F0];
				register_bank_switch_ff <= acc_ff[`MIE_PSW_BS];
				stack_ptr_ff <= acc_ff[`MIE_SP_HI:0];
			end
			`MIE_MOV_A_R, `MIE_XCH_R:
				acc_ff <= r_val;
			`MIE_MOV_A_I, `MIE_XCH_I:
				acc_ff <= i_val;
			`MIE_LOW_NIBBLE_EXCHANGE:
				acc_ff <= alu_res;
			`MIE_EXTERNAL_DATA_MOVE_RD:
			begin
				xd_addr_ff <= ptr_val;
				xd_rd_ff <= 1'b1;
			end
			`MIE_EXTERNAL_DATA_MOVE_WR:
			begin
				xd_addr_ff <= ptr_val;
				xd_wdata_ff <= acc_ff;
				xd_wr_ff <= 1'b1;
			end
			`MIE_CPL_C:
				carry_ff <= !carry_ff;
			`MIE_CLR_C:
				carry_ff <= 1'b0;
			`MIE_CPL_F0:
				user_flag_zero_ff <= !user_flag_zero_ff;
			`MIE_CLR_F0:
				user_flag_zero_ff <= 1'b0;
			`MIE_CPL_F1:
				user_flag_one_ff <= !user_flag_one_ff;
			`MIE_CLR_F1:
				user_flag_one_ff <= 1'b0;
			default:
				acc_ff <= acc_ff;
			endcase
		end
		else if (in_arg)
		begin
			casez (op_ff)
			`MIE_XRL_IMM:
				acc_ff <= alu_res;
			`MIE_MOV_A_IMM, `MIE_CURRENT_PAGE_TABLE_READ, `MIE_PAGE_THREE_TABLE_READ:
				acc_ff <= prog_data;
			`MIE_EXTERNAL_DATA_MOVE_RD:
				acc_ff <= xd_rdata;
			default:
				acc_ff <= acc_ff;
			endcase
		end
	end
end

endmodule // mie_exec_core

// ---- test/mie_exec_properties.sv ----
`timescale 1ns/10ps
module mie_exec_properties (
	input wire clock,
	input wire arst_n,
	input wire [7:0] prog_data,
	input wire prog_rd_ff,
	input wire [7:0] xd_rdata,
	input wire [7:0] xd_wdata_ff,
	input wire xd_rd_ff,
	input wire xd_wr_ff,
	input wire [11:0] pc_ff,
	input wire [7:0] acc_ff,
	input wire carry_ff,
	input wire program_bank_flag_ff,
	input wire instr_done_ff
);
	logic seen_ff;
	logic [7:0] a1_ff;
	logic [7:0] d1_ff;
	logic [7:0] d2_ff;
	// opcode cycle: first fetch after reset, or the one flagged by done
	wire op_cyc = prog_rd_ff && (instr_done_ff || !seen_ff);
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			seen_ff <= 1'b0;
			a1_ff <= 8'h00;
			d1_ff <= 8'h00;
			d2_ff <= 8'h00;
		end
		else
		begin
			seen_ff <= seen_ff | prog_rd_ff;
			a1_ff <= acc_ff;
			d1_ff <= prog_data;
			d2_ff <= d1_ff;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	sequence s_two_byte(op);
		op_cyc && prog_data == op ##1 !instr_done_ff;
	endsequence
	sequence s_jmp;
		op_cyc && prog_data[4:0] == 5'h04 ##1 1'b1;
	endsequence
	property p_rl;
		op_cyc && prog_data == 8'hE7 |=>
			acc_ff == {a1_ff[6:0], a1_ff[7]} && carry_ff == $past(carry_ff);
	endproperty
	a_rl: assert property (p_rl) else $error("rl wrong");
	property p_rlc;
		op_cyc && prog_data == 8'hF7 |=>
			acc_ff == {a1_ff[6:0], $past(carry_ff)} && carry_ff == a1_ff[7];
	endproperty
	a_rlc: assert property (p_rlc) else $error("rlc wrong");
	property p_swap;
		op_cyc && prog_data == 8'h47 |=>
			acc_ff == {a1_ff[3:0], a1_ff[7:4]} && instr_done_ff;
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");
	property p_xrl_imm;
		s_two_byte(8'hD3) |=>
			acc_ff == ($past(acc_ff, 2) ^ d1_ff) && instr_done_ff;
	endproperty
	a_xrl_imm: assert property (p_xrl_imm) else $error("xrl wrong");
	property p_xrd;
		op_cyc && prog_data[7:1] == 7'h40 |=> xd_rd_ff && !prog_rd_ff
			##1 acc_ff == $past(xd_rdata) && !xd_rd_ff && prog_rd_ff;
	endproperty
	a_xrd: assert property (p_xrd) else $error("ext read wrong");
	property p_xwr;
		op_cyc && prog_data[7:1] == 7'h48 |=> xd_wr_ff &&
			xd_wdata_ff == a1_ff ##1 !xd_wr_ff && instr_done_ff;
	endproperty
	a_xwr: assert property (p_xwr) else $error("ext write wrong");
	property p_jmp;
		s_jmp |=> pc_ff == {$past(program_bank_flag_ff, 2), d2_ff[7:5], d1_ff};
	endproperty
	a_jmp: assert property (p_jmp) else $error("jump wrong");
	property p_clr_c;
		op_cyc && prog_data == 8'h97 |=> !carry_ff;
	endproperty
	a_clr_c: assert property (p_clr_c) else $error("clr c wrong");
	property p_undef;
		op_cyc && prog_data == 8'h01 |=> instr_done_ff &&
			acc_ff == a1_ff && $stable(carry_ff);
	endproperty
	a_undef: assert property (p_undef) else $error("no-op wrong");
endmodule // mie_exec_properties
bind mie_exec_core mie_exec_properties u_props (.clock, .arst_n,
	.prog_data, .prog_rd_ff, .xd_rdata, .xd_wdata_ff, .xd_rd_ff, .xd_wr_ff,
	.pc_ff, .acc_ff, .carry_ff, .program_bank_flag_ff, .instr_done_ff);

// ---- test/mie_mem_model.sv ----
`timescale 1ns/10ps
module mie_mem_model (
	input wire clock,
	input wire [11:0] prog_addr_ff,
	input wire prog_rd_ff,
	input wire [7:0] xd_addr_ff,
	input wire [7:0] xd_wdata_ff,
	input wire xd_rd_ff,
	input wire xd_wr_ff,
	output wire [7:0] prog_data,
	output wire [7:0] xd_rdata
);
	logic [7:0] pmem [0:4095];
	logic [7:0] xmem [0:255];
	logic [7:0] last_p = 8'h00;
	logic [7:0] last_x = 8'h00;
	integer i;
	initial
		for (i = 0; i < 256; i = i + 1)
			xmem[i] = 8'h00;
	// a released bus shows the inverted last byte, so stale data never matches
	assign prog_data = prog_rd_ff ? pmem[prog_addr_ff] : ~last_p;
	assign xd_rdata = xd_rd_ff ? xmem[xd_addr_ff] : ~last_x;
	always @(posedge clock)
	begin
		if (prog_rd_ff)
			last_p <= prog_data;
		if (xd_rd_ff)
			last_x <= xd_rdata;
		if (xd_wr_ff)
			xmem[xd_addr_ff] <= xd_wdata_ff;
	end
endmodule // mie_mem_model

// ---- test/test_mcu_instruction_execute_subset.sv ----
`timescale 1ns/10ps
module test_mcu_instruction_execute_subset;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic test_input_zero = 1'b1;
	logic test_input_one = 1'b1;
	logic ext_int_n = 1'b0;
	wire [7:0] prog_data, xd_rdata, xd_addr_ff, xd_wdata_ff, acc_ff;
	wire [11:0] prog_addr_ff, pc_ff;
	wire prog_rd_ff, xd_rd_ff, xd_wr_ff, carry_ff, user_flag_zero_ff;
	wire instr_done_ff;
	wire user_flag_one_ff, register_bank_switch_ff, program_bank_flag_ff;
	wire ext_int_enable_ff;
	integer n_mismatch = 0;
	integer n_checks = 0;
	integer k;
	localparam [535:0] PROG = {128'h2381E7A7F7677747D3FFB84090230080,
		128'hC6559616000097E61B0000F21F0000D8,
		128'h0195B6260000362A0000460086300000,
		128'hD5C72305A32302E3233CB30040000000, 24'hF52450};
	always #12.5 clock = ~clock;
	mie_exec_core DUT (.clock, .arst_n, .prog_data, .xd_rdata,
		.test_input_zero, .test_input_one, .ext_int_n, .prog_addr_ff,
		.prog_rd_ff, .xd_addr_ff, .xd_wdata_ff, .xd_rd_ff, .xd_wr_ff,
		.pc_ff, .acc_ff, .carry_ff, .aux_carry_ff(), .user_flag_zero_ff,
		.user_flag_one_ff, .register_bank_switch_ff,
		.program_bank_flag_ff, .ext_int_enable_ff, .instr_done_ff);
	mie_mem_model mem (.clock, .prog_addr_ff, .prog_rd_ff, .xd_addr_ff,
		.xd_wdata_ff, .xd_rd_ff, .xd_wr_ff, .prog_data, .xd_rdata);
	task chk(input logic [11:0] seen, input logic [11:0] exp);
	begin
		n_checks = n_checks + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// waits for the next completion pulse, then checks pc, acc and carry
	task st(input logic [11:0] pc, input logic [7:0] acc, input logic cy);
		integer i;
	begin
		i = 0;
		@(negedge clock);
		while (instr_done_ff !== 1'b1 && i < 8)
		begin
			@(negedge clock);
			i = i + 1;
		end
		chk({11'h000, instr_done_ff}, 12'h001);
		chk(pc_ff, pc);
		chk({4'h0, acc_ff}, {4'h0, acc});
		chk({11'h000, carry_ff}, {11'h000, cy});
	end
	endtask
	task summarize;
	begin
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	initial
	begin
		#(25 * 2000);
		n_mismatch = n_mismatch + 1;
		summarize;
	end
	initial
	begin
		for (k = 0; k < 67; k = k + 1)
			mem.pmem[k] = PROG[8 * (66 - k) +: 8];
		mem.pmem[12'h302] = 8'h5A;
		// back to register bank 0, where r0 was loaded with 40
		mem.pmem[12'h950] = 8'hC5;
		mem.pmem[12'h951] = 8'h28;
		mem.pmem[12'h952] = 8'h05;
		mem.pmem[12'h953] = 8'hB5;
		mem.pmem[12'h954] = 8'hD7;
		repeat (5) @(negedge clock);
		arst_n = 1'b1;
		st(12'h002, 8'h81, 1'b0);
		st(12'h003, 8'h03, 1'b0);
		st(12'h004, 8'h03, 1'b1);
		st(12'h005, 8'h07, 1'b0);
		st(12'h006, 8'h03, 1'b1);
		st(12'h007, 8'h81, 1'b1);
		st(12'h008, 8'h18, 1'b1);
		st(12'h00A, 8'hE7, 1'b1);
		st(12'h00C, 8'hE7, 1'b1);
		st(12'h00D, 8'hE7, 1'b1);
		chk({4'h0, mem.xmem[8'h40]}, 12'h0E7);
		st(12'h00F, 8'h00, 1'b1);
		st(12'h010, 8'hE7, 1'b1);
		st(12'h012, 8'hE7, 1'b1);
		st(12'h016, 8'hE7, 1'b1);
		st(12'h017, 8'hE7, 1'b0);
		st(12'h01B, 8'hE7, 1'b0);
		st(12'h01F, 8'hE7, 1'b0);
		st(12'h020, 8'hA7, 1'b0);
		st(12'h021, 8'hA7, 1'b0);
		st(12'h022, 8'hA7, 1'b0);
		chk({11'h000, user_flag_zero_ff}, 12'h001);
		st(12'h026, 8'hA7, 1'b0);
		st(12'h02A, 8'hA7, 1'b0);
		st(12'h02C, 8'hA7, 1'b0);
		st(12'h030, 8'hA7, 1'b0);
		st(12'h031, 8'hA7, 1'b0);
		st(12'h032, 8'h38, 1'b0);
		st(12'h034, 8'h05, 1'b0);
		st(12'h035, 8'h67, 1'b0);
		st(12'h037, 8'h02, 1'b0);
		st(12'h038, 8'h5A, 1'b0);
		st(12'h03A, 8'h3C, 1'b0);
		st(12'h040, 8'h3C, 1'b0);
		st(12'h041, 8'h3C, 1'b0);
		st(12'h950, 8'h3C, 1'b0);
		st(12'h951, 8'h3C, 1'b0);
		st(12'h952, 8'h40, 1'b0);
		chk({11'h000, register_bank_switch_ff}, 12'h000);
		chk({11'h000, program_bank_flag_ff}, 12'h001);
		st(12'h953, 8'h40, 1'b0);
		chk({11'h000, ext_int_enable_ff}, 12'h001);
		st(12'h954, 8'h40, 1'b0);
		chk({11'h000, user_flag_one_ff}, 12'h001);
		st(12'h955, 8'h40, 1'b0);
		chk({11'h000, user_flag_zero_ff}, 12'h000);
		$display("test instruction walk done");
		summarize;
	end
endmodule // test_mcu_instruction_execute_subset
